// >>> hw/tecq_pkg.sv
// Shared constants and carrier types of the event counter channel.
package tecq_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RELOAD = 8'h0c;
    localparam int ADDR_LSB_W = 8;
    localparam int STATUS_WRAP_BIT = 3;

    // ------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] AUX_PORT = 2'h0;
    localparam logic [1:0] AUX_PULSE = 2'h1;
    localparam logic [1:0] AUX_DIR = 2'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ------------------------------------------------------------------
    // Counter limits and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_MIN = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam int CTRL_W = 15;
    localparam int STATUS_W = 5;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic gpio_drive;
        logic gpio_level;
        logic mul4;
        logic two_phase;
        logic free_run;
        logic [1:0] aux_fn;
        logic dir_up;
        logic tmr_sibling;
        logic src_timer;
        logic [1:0] edge_sel;
        logic start;
        logic [1:0] mode;
    } tecq_ctrl_t;

    localparam tecq_ctrl_t CTRL_RST = 15'h0000;

    typedef struct packed {
        logic running;
        logic wrap_flag;
        logic aux_out;
        logic aux_in;
        logic cnt_in;
    } tecq_status_t;

    typedef struct packed {
        logic aux;
        logic cnt;
    } tecq_pins_t;

    typedef struct packed {
        logic ev;
        logic up;
    } tecq_step_t;

endpackage

// >>> hw/tecq_pin_sync.sv
// Two-stage synchroniser with one extra stage for edge detection.
module tecq_pin_sync (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw pins
    input tecq_pkg::tecq_pins_t pins,
    // Synchronised levels
    output tecq_pkg::tecq_pins_t cur,
    output tecq_pkg::tecq_pins_t prev
);

    tecq_pkg::tecq_pins_t meta;

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    // The first stage feeds only the second; edges are taken between the
    // second and third, so a slow edge is seen exactly once.
    // synchronise before detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= 2'h0;
            cur <= 2'h0;
            prev <= 2'h0;
        end else begin
            meta <= pins;
            cur <= meta;
            prev <= cur;
        end
    end

endmodule

// >>> hw/tecq_channel.sv
// One 16-bit event counter channel with quadrature decode (two-phase on channels two and above, times-four on three and four only) and AHB-Lite.
module tecq_channel #(
    parameter int CHANNEL = 0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins
    input wire logic count_input_pin,
    input wire logic aux_io_pin_in,
    output logic aux_io_pin_out,
    output logic aux_io_pin_oe_n,
    // Wrap events of other timers
    input wire logic second_group_timer_two_ev,
    input wire logic sibling_channel_timer_ev,
    // Request
    output logic count_irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic p, input logic c);
        logic rise;
        logic fall;
        rise = c & ~p;
        fall = p & ~c;
        case (sel)
            tecq_pkg::EDGE_FALL: edge_hit = fall;
            tecq_pkg::EDGE_RISE: edge_hit = rise;
            tecq_pkg::EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // A legal quadrature step changes exactly one phase; the sense is the
    // old input level against the new aux level.
    function automatic tecq_pkg::tecq_step_t quad_step(
        input tecq_pkg::tecq_pins_t p, input tecq_pkg::tecq_pins_t c);
        tecq_pkg::tecq_step_t s;
        s.ev = (p.cnt ^ c.cnt) ^ (p.aux ^ c.aux);
        s.up = p.cnt ^ c.aux;
        quad_step = s;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    tecq_pkg::tecq_ctrl_t ctrl;
    tecq_pkg::tecq_pins_t raw_pins;
    tecq_pkg::tecq_pins_t cur;
    tecq_pkg::tecq_pins_t prev;
    tecq_pkg::tecq_step_t step;
    tecq_pkg::tecq_status_t status;
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [15:0] next_cnt;
    logic wrap_flag;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic rd_take;
    logic wr_take;
    logic wr_ctrl;
    logic wr_timer;
    logic wr_status;
    logic running;
    logic two_ph;
    logic mul4_eff;
    logic dir_sel;
    logic tick;
    logic wrap;
    logic pulse_en;
    logic next_oe_n;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    assign raw_pins.cnt = count_input_pin;
    assign raw_pins.aux = aux_io_pin_in;

    tecq_pin_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins(raw_pins),
        .cur(cur),
        .prev(prev)
    );

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Every NONSEQ transfer is taken with no wait state; the upper address bits
    // are not decoded, so the block repeats across its select window.
    assign addr_ok = hsel && hready && (htrans == tecq_pkg::HTRANS_NONSEQ);
    assign rd_take = addr_ok && !hwrite;
    assign wr_take = addr_ok && hwrite;
    assign wr_ctrl = wr_pend && (wr_addr == tecq_pkg::ADDR_CTRL);
    assign wr_timer = wr_pend && (wr_addr == tecq_pkg::ADDR_TIMER);
    assign wr_status = wr_pend && (wr_addr == tecq_pkg::ADDR_STATUS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= wr_take;
            wr_addr <= haddr[tecq_pkg::ADDR_LSB_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign status = '{running: running, wrap_flag: wrap_flag,
                      aux_out: aux_io_pin_out, aux_in: cur.aux,
                      cnt_in: cur.cnt};

    // Read data is fetched in the address phase, so it stands from the
    // flop for the whole data phase.
    // register readback
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            case (haddr[tecq_pkg::ADDR_LSB_W-1:0])
                tecq_pkg::ADDR_CTRL: hrdata <= {17'h00000, ctrl};
                tecq_pkg::ADDR_TIMER: hrdata <= {16'h0000, cnt};
                tecq_pkg::ADDR_STATUS: hrdata <= {27'h0000000, status};
                tecq_pkg::ADDR_RELOAD: hrdata <= {16'h0000, reload};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= tecq_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= hwdata[tecq_pkg::CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Count source and direction
    // ------------------------------------------------------------------
    // gate on start flag
    assign running = ctrl.start && (ctrl.mode == tecq_pkg::MODE_EVENT);
    // two-phase only channels two and above
    assign two_ph = (CHANNEL >= 2) && ctrl.two_phase;
    assign mul4_eff = (CHANNEL == 4) || ((CHANNEL == 3) && ctrl.mul4);
    assign dir_sel = (ctrl.aux_fn == tecq_pkg::AUX_DIR) ? cur.aux
                                                        : ctrl.dir_up;

    always_comb begin
        step = 2'h0;
        if (two_ph) begin
            if (mul4_eff) begin
                step = quad_step(prev, cur);
            end else begin
                step.ev = cur.aux && (cur.cnt != prev.cnt);
                step.up = cur.cnt;
            end
        end else if (ctrl.src_timer) begin
            step.ev = ctrl.tmr_sibling ? sibling_channel_timer_ev
                                       : second_group_timer_two_ev;
            step.up = dir_sel;
        end else begin
            step.ev = edge_hit(ctrl.edge_sel, prev.cnt, cur.cnt);
            step.up = dir_sel;
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign tick = running && step.ev;
    assign wrap = tick && (step.up ? (cnt == tecq_pkg::CNT_MAX)
                                   : (cnt == tecq_pkg::CNT_MIN));

    always_comb begin
        next_cnt = cnt;
        if (wrap) begin
            if (ctrl.free_run) begin
                next_cnt = step.up ? tecq_pkg::CNT_MIN : tecq_pkg::CNT_MAX;
            end else begin
                next_cnt = reload;
            end
        end else if (tick) begin
            next_cnt = step.up ? cnt + 16'h0001 : cnt - 16'h0001;
        end
    end

    // A write while stopped loads both; while running only the reload
    // value changes and reaches the counter at the next wrap while free_run is clear.
    // stopped write loads counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= tecq_pkg::CNT_RST;
        end else if (wr_timer && !running) begin
            cnt <= hwdata[15:0];
        end else begin
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload <= tecq_pkg::RELOAD_RST;
        end else if (wr_timer) begin
            reload <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_irq <= 1'b0;
        end else begin
            count_irq <= wrap;
        end
    end

    // A wrap in the same cycle as the clearing write keeps the flag set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_flag <= 1'b0;
        end else if (wrap) begin
            wrap_flag <= 1'b1;
        end else if (wr_status && hwdata[tecq_pkg::STATUS_WRAP_BIT]) begin
            wrap_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Aux pin
    // ------------------------------------------------------------------
    assign pulse_en = !two_ph && (ctrl.aux_fn == tecq_pkg::AUX_PULSE);

    always_comb begin
        next_oe_n = 1'b1;
        if (!two_ph) begin
            case (ctrl.aux_fn)
                tecq_pkg::AUX_PORT: next_oe_n = !ctrl.gpio_drive;
                tecq_pkg::AUX_PULSE: next_oe_n = 1'b0;
                tecq_pkg::AUX_DIR: next_oe_n = 1'b1;
                default: next_oe_n = 1'b1;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_io_pin_out <= 1'b0;
            aux_io_pin_oe_n <= 1'b1;
        end else begin
            aux_io_pin_out <= pulse_en ? (aux_io_pin_out ^ wrap)
                                       : ctrl.gpio_level;
            aux_io_pin_oe_n <= next_oe_n;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wrap_reload;
        wrap && !ctrl.free_run && !wr_timer;
    endsequence

    sequence s_run_write;
        wr_timer && running;
    endsequence

    AST_STOP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !running && !wr_timer |=> $stable(cnt))
        else $error("counter moved while stopped");

    AST_IRQ_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap |=> count_irq ##1 (!count_irq || $past(wrap)))
        else $error("request does not follow wrap");

    AST_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wrap_reload |=> cnt == $past(reload))
        else $error("counter not reloaded on wrap");

    AST_FREE_UP: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap && ctrl.free_run && step.up && !wr_timer |=> cnt == 16'h0000)
        else $error("free-run overflow did not wrap to zero");

    AST_WR_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_timer && !running |=> cnt == $past(hwdata[15:0])
                                 && reload == $past(hwdata[15:0]))
        else $error("stopped write did not load counter");

    AST_WR_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        s_run_write ##0 !tick |=> $stable(cnt)
                                  && reload == $past(hwdata[15:0]))
        else $error("running write touched the counter");

    AST_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
        pulse_en && $past(pulse_en) |-> (aux_io_pin_out
            != $past(aux_io_pin_out)) == $past(wrap))
        else $error("pulse output out of step with wraps");

    AST_NO_2PH_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        (CHANNEL < 2) |-> !two_ph)
        else $error("two-phase active on low channel");

    AST_2PH_INPUT: assert property (@(posedge hclk) disable iff (!hresetn)
        two_ph && $past(two_ph) |-> aux_io_pin_oe_n)
        else $error("aux pin driven in two-phase mode");

    AST_UP_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && step.up && !wrap && !wr_timer |=>
            cnt == $past(cnt) + 16'h0001)
        else $error("up count step wrong");

endmodule

// >>> tb/tecq_enc_model.sv
// Model of the external pulse source and two-phase encoder.
module tecq_enc_model (
    // Clock
    input wire logic hclk,
    // Device side of the aux pin
    input wire logic dev_out,
    input wire logic dev_oe_n,
    // Lines seen by the device
    output logic cnt_pin,
    output logic aux_line
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 6;
    logic [1:0] pos = 2'h0;
    logic aux_val = 1'b0;
    logic aux_en = 1'b0;
    initial cnt_pin = 1'b0;
    // A released line shows the inverse of its last value, not a copy.
    assign aux_line = !dev_oe_n ? dev_out : aux_en ? aux_val : ~aux_val;
    // Levels stand for hold cycles so the device sees each one once.
    task automatic settle();
        repeat (hold) @(posedge hclk);
    endtask
    task automatic set_cnt(input logic v);
        @(posedge hclk);
        cnt_pin <= v;
        settle();
    endtask
    task automatic set_aux(input logic v, input logic en);
        @(posedge hclk);
        aux_val <= v;
        aux_en <= en;
        settle();
    endtask
    // Gray steps (cnt,aux): 00, 01, 11, 10 when turning forward.
    task automatic quad(input logic up, input int n);
        for (int i = 0; i < n; i++) begin
            pos = up ? pos + 2'h1 : pos - 2'h1;
            @(posedge hclk);
            cnt_pin <= pos[1];
            aux_val <= pos[1] ^ pos[0];
            settle();
        end
    endtask
endmodule

// >>> tb/timer_event_counter_quadrature_tb_top.sv
// Self-checking bench of the event counter channel.
module timer_event_counter_quadrature_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic cnt_pin;
    logic aux_line;
    logic aux_out;
    logic aux_oe_n;
    logic ev_tb2;
    logic ev_sib;
    logic count_irq;
    int num_errors = 0;
    int num_checks = 0;
    int irq_n = 0;
    tecq_pkg::tecq_ctrl_t c;
    logic [31:0] edge_exp [4] = '{32'h1, 32'h1, 32'h2, 32'h0};

    initial hclk = 1'b0;
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (count_irq === 1'b1) irq_n <= irq_n + 1;

    tecq_channel #(.CHANNEL(3)) tecq_channel_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .count_input_pin(cnt_pin), .aux_io_pin_in(aux_line),
        .aux_io_pin_out(aux_out), .aux_io_pin_oe_n(aux_oe_n),
        .second_group_timer_two_ev(ev_tb2),
        .sibling_channel_timer_ev(ev_sib), .count_irq(count_irq)
    );
    tecq_enc_model tecq_enc_model_inst (
        .hclk(hclk), .dev_out(aux_out), .dev_oe_n(aux_oe_n),
        .cnt_pin(cnt_pin), .aux_line(aux_line)
    );

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (n == 50) num_errors++;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= tecq_pkg::HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Registered pin outputs follow a control write one edge later, so
    // they are looked at on falling edges once they have settled.
    task automatic idle(input int n);
        repeat (n) @(negedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        cmp(rd, exp);
    endtask
    task automatic wctrl();
        wr(tecq_pkg::ADDR_CTRL, {17'h0, c});
    endtask
    task automatic ev(input logic sib, input int n);
        repeat (n) begin
            @(posedge hclk);
            ev_sib <= sib;
            ev_tb2 <= !sib;
            @(posedge hclk);
            ev_sib <= 1'b0;
            ev_tb2 <= 1'b0;
            @(posedge hclk);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        ev_tb2 <= 1'b0;
        ev_sib <= 1'b0;
        repeat (6) @(posedge hclk);
        cmp({31'h0, aux_oe_n}, 32'h1);
        hresetn <= 1'b1;
        cmp({31'h0, hresp}, 32'h0);
        chk(tecq_pkg::ADDR_CTRL, 32'h0);
        chk(tecq_pkg::ADDR_TIMER, 32'h0);
        chk(8'h10, 32'h0);
        $display("test reset done");
        wr(tecq_pkg::ADDR_TIMER, 32'h2);
        chk(tecq_pkg::ADDR_TIMER, 32'h2);
        chk(tecq_pkg::ADDR_RELOAD, 32'h2);
        c = tecq_pkg::CTRL_RST;
        c.mode = tecq_pkg::MODE_EVENT;
        c.src_timer = 1'b1;
        c.aux_fn = tecq_pkg::AUX_PULSE;
        c.start = 1'b1;
        wctrl();
        idle(2);
        cmp({31'h0, aux_oe_n}, 32'h0);
        ev(1'b0, 3);
        chk(tecq_pkg::ADDR_TIMER, 32'h2);
        cmp(irq_n, 32'h1);
        cmp({31'h0, aux_out}, 32'h1);
        wr(tecq_pkg::ADDR_TIMER, 32'h5);
        chk(tecq_pkg::ADDR_TIMER, 32'h2);
        chk(tecq_pkg::ADDR_RELOAD, 32'h5);
        c.tmr_sibling = 1'b1;
        wctrl();
        ev(1'b1, 3);
        chk(tecq_pkg::ADDR_TIMER, 32'h5);
        cmp(irq_n, 32'h2);
        cmp({31'h0, aux_out}, 32'h0);
        c.start = 1'b0;
        wctrl();
        ev(1'b1, 2);
        chk(tecq_pkg::ADDR_TIMER, 32'h5);
        $display("test timer events down done");
        wr(tecq_pkg::ADDR_TIMER, 32'hfffe);
        c.dir_up = 1'b1;
        c.start = 1'b1;
        wctrl();
        ev(1'b1, 2);
        chk(tecq_pkg::ADDR_TIMER, 32'hfffe);
        cmp(irq_n, 32'h3);
        c.start = 1'b0;
        wctrl();
        wr(tecq_pkg::ADDR_TIMER, 32'hffff);
        c.free_run = 1'b1;
        c.start = 1'b1;
        wctrl();
        ev(1'b1, 1);
        chk(tecq_pkg::ADDR_TIMER, 32'h0);
        cmp(irq_n, 32'h4);
        cmp({31'h0, aux_out}, 32'h0);
        chk(tecq_pkg::ADDR_STATUS, 32'h18);
        wr(tecq_pkg::ADDR_STATUS, 32'h8);
        chk(tecq_pkg::ADDR_STATUS, 32'h10);
        $display("test up and free-run done");
        c = tecq_pkg::CTRL_RST;
        c.mode = tecq_pkg::MODE_EVENT;
        c.dir_up = 1'b1;
        c.gpio_drive = 1'b1;
        c.gpio_level = 1'b1;
        for (int e = 0; e < 4; e++) begin
            c.start = 1'b0;
            wctrl();
            wr(tecq_pkg::ADDR_TIMER, 32'h0);
            c.edge_sel = e[1:0];
            c.start = 1'b1;
            wctrl();
            cmp({30'h0, aux_oe_n, aux_out}, 32'h1);
            tecq_enc_model_inst.set_cnt(1'b1);
            tecq_enc_model_inst.set_cnt(1'b0);
            chk(tecq_pkg::ADDR_TIMER, edge_exp[e]);
        end
        $display("test pin edges done");
        tecq_enc_model_inst.set_aux(1'b1, 1'b1);
        c.aux_fn = tecq_pkg::AUX_DIR;
        c.edge_sel = tecq_pkg::EDGE_RISE;
        wctrl();
        idle(2);
        cmp({31'h0, aux_oe_n}, 32'h1);
        tecq_enc_model_inst.set_cnt(1'b1);
        tecq_enc_model_inst.set_cnt(1'b0);
        chk(tecq_pkg::ADDR_TIMER, 32'h1);
        tecq_enc_model_inst.set_aux(1'b0, 1'b1);
        tecq_enc_model_inst.set_cnt(1'b1);
        tecq_enc_model_inst.set_cnt(1'b0);
        chk(tecq_pkg::ADDR_TIMER, 32'h0);
        $display("test direction input done");
        c.two_phase = 1'b1;
        wctrl();
        idle(2);
        cmp({31'h0, aux_oe_n}, 32'h1);
        tecq_enc_model_inst.set_cnt(1'b1);
        tecq_enc_model_inst.set_cnt(1'b0);
        chk(tecq_pkg::ADDR_TIMER, 32'h0);
        tecq_enc_model_inst.set_aux(1'b1, 1'b1);
        tecq_enc_model_inst.set_cnt(1'b1);
        chk(tecq_pkg::ADDR_TIMER, 32'h1);
        tecq_enc_model_inst.set_cnt(1'b0);
        chk(tecq_pkg::ADDR_TIMER, 32'h0);
        tecq_enc_model_inst.set_aux(1'b0, 1'b1);
        $display("test normal two-phase done");
        c.mul4 = 1'b1;
        wctrl();
        tecq_enc_model_inst.hold = 3;
        tecq_enc_model_inst.quad(1'b1, 4);
        tecq_enc_model_inst.hold = 6;
        tecq_enc_model_inst.settle();
        chk(tecq_pkg::ADDR_TIMER, 32'h4);
        tecq_enc_model_inst.quad(1'b0, 3);
        chk(tecq_pkg::ADDR_TIMER, 32'h1);
        $display("test times-four done");
        end_of_test();
    end
endmodule
